// *** verilog/ucpe_pkg.sv ***
// Shared constants, decode helpers and carriers for the charge-port emulator
package ucpe_pkg;
    // Register offsets
    localparam logic [7:0] UCPE_OFS_ID   = 8'h00;
    localparam logic [7:0] UCPE_OFS_TRIM = 8'h01;
    localparam logic [7:0] UCPE_OFS_PWR  = 8'h02;
    localparam logic [7:0] UCPE_OFS_MODE = 8'h03;
    localparam logic [7:0] UCPE_OFS_RSVD = 8'h04;
    localparam logic [7:0] UCPE_OFS_SW   = 8'h05;
    localparam logic [7:0] UCPE_OFS_EVT  = 8'h06;
    localparam logic [7:0] UCPE_OFS_LIVE = 8'h07;
    localparam logic [7:0] UCPE_OFS_MASK = 8'h08;
    // Reset values
    localparam logic [7:0] UCPE_RST_TRIM = 8'h87;
    localparam logic [7:0] UCPE_RST_PWR  = 8'h50;
    localparam logic [7:0] UCPE_RST_MODE = 8'he9;
    localparam logic [7:0] UCPE_RST_RSVD = 8'h00;
    localparam logic [7:0] UCPE_RST_SW   = 8'h7b;
    localparam logic [7:0] UCPE_RST_EVT  = 8'h00;
    localparam logic [7:0] UCPE_RST_LIVE = 8'h00;
    localparam logic [7:0] UCPE_RST_MASK = 8'h00;
    // Field positions
    localparam int UCPE_SLEEP_BIT  = 7;
    localparam int UCPE_CDPOFF_BIT = 1;
    localparam int UCPE_MODE_MSB   = 2;
    localparam int UCPE_LIVE_DEV   = 7;
    localparam int UCPE_LIVE_BYP   = 6;
    localparam int UCPE_LIVE_CONN  = 5;
    // Mode field encodings
    localparam logic [2:0] autodetect_2a_mode     = 3'h0;
    localparam logic [2:0] passthru_mode          = 3'h1;
    localparam logic [2:0] forced_short_mode      = 3'h2;
    localparam logic [2:0] passthru_cdp_emul_mode = 3'h3;
    localparam logic [2:0] autodetect_1a_mode     = 3'h4;
    // Serial slave figures
    localparam logic [6:0] UCPE_ADDR_MIN = 7'h08;
    localparam logic [3:0] UCPE_BITS     = 4'h8;

    typedef struct packed {
        logic port_pos_line_high;
        logic port_neg_line_high;
        logic cdp_detected;
    } ucpe_cmp_s;

    typedef struct packed {
        logic div_en;
        logic short_en;
        logic pulldown_en;
        logic xcvr_connect;
        logic cdp_adv;
    } ucpe_line_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ucpe_bus_s;

    // Either automatic detection charger mode
    function automatic logic ucpe_is_auto(input logic [2:0] m);
        return (m == autodetect_2a_mode) || (m == autodetect_1a_mode);
    endfunction
endpackage

// *** verilog/ucpe_i2c.sv ***
`timescale 1ns/10ps
// Serial management slave: pointer byte, then written or read data bytes
module ucpe_i2c #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic           i_clk,
    input  wire logic           i_resetn,
    input  wire logic           i_scl,
    input  wire logic           i_sda_in,
    output logic                o_sda_out,
    output logic                o_sda_oe,
    input  wire logic [7:0]     i_rdata,
    output logic                o_rd,
    output ucpe_pkg::ucpe_bus_s o_bus
);
    import ucpe_pkg::*;

    typedef enum {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA} ucpe_i2c_e;
    typedef struct packed {
        ucpe_i2c_e  st;
        logic       scl;
        logic       sda;
        logic [3:0] cnt;
        logic       ack;
        logic       rw;
        logic       nack;
        logic       oe;
        logic [7:0] sh;
        ucpe_bus_s  bus;
    } ucpe_i2c_s;

    ucpe_i2c_s q, d;
    logic      start, stop, rise, fall;

    if (DEV_ADDR < UCPE_ADDR_MIN) begin : g_chk
        $error("device address falls in the reserved range");
    end

    // Line events seen against last sample
    assign start = q.scl && i_scl && q.sda && !i_sda_in;
    assign stop  = q.scl && i_scl && !q.sda && i_sda_in;
    assign rise  = !q.scl && i_scl;
    assign fall  = q.scl && !i_scl;

    // Open drain: only ever pull low
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = q.oe;
    assign o_bus     = q.bus;

    // Byte engine; data changes only while the clock line is low
    always_comb begin
        d        = q;
        d.scl    = i_scl;
        d.sda    = i_sda_in;
        d.bus.wr = 1'b0;
        o_rd     = 1'b0;
        if (start) begin
            d.st   = S_ADDR;
            d.cnt  = 4'h0;
            d.ack  = 1'b0;
            d.nack = 1'b0;
            d.oe   = 1'b0;
        end else if (stop) begin
            d.st = S_IDLE;
            d.oe = 1'b0;
        end else if (q.st != S_IDLE) begin
            if (rise && !q.ack) begin
                d.cnt = q.cnt + 4'h1;
                if (q.st != S_RDATA) begin
                    d.sh = {q.sh[6:0], i_sda_in};
                end
            end
            if (rise && q.ack && q.st == S_RDATA) begin
                d.nack = i_sda_in;
            end
            if (fall) begin
                if (!q.ack && q.cnt == UCPE_BITS) begin
                    d.ack = 1'b1;
                    d.oe  = 1'b1;
                    case (q.st)
                        S_ADDR: begin
                            if (q.sh[7:1] != DEV_ADDR) begin
                                d.st = S_IDLE;
                                d.oe = 1'b0;
                            end else begin
                                d.rw = q.sh[0];
                            end
                        end
                        S_PTR:   d.bus.addr = q.sh;
                        S_WDATA: begin
                            d.bus.wr    = 1'b1;
                            d.bus.wdata = q.sh;
                        end
                        S_RDATA: begin
                            d.oe       = 1'b0;
                            d.bus.addr = q.bus.addr + 8'h01;
                        end
                        default: d.st = S_IDLE;
                    endcase
                end else if (q.ack) begin
                    d.ack = 1'b0;
                    d.cnt = 4'h0;
                    d.oe  = 1'b0;
                    case (q.st)
                        S_ADDR:  d.st = q.rw ? S_RDATA : S_PTR;
                        S_PTR:   d.st = S_WDATA;
                        S_WDATA: d.bus.addr = q.bus.addr + 8'h01;
                        S_RDATA: d.st = q.nack ? S_IDLE : S_RDATA;
                        default: d.st = S_IDLE;
                    endcase
                    // Load next read byte and put out its top bit
                    if (d.st == S_RDATA) begin
                        o_rd = 1'b1;
                        d.sh = i_rdata;
                        d.oe = !i_rdata[7];
                    end
                end else if (q.st == S_RDATA) begin
                    d.sh = {q.sh[6:0], 1'b0};
                    d.oe = !q.sh[6];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            // Lines idle high, so release after reset shows no false edge
            q     <= '0;
            q.scl <= 1'b1;
            q.sda <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

// *** verilog/ucpe_line.sv ***
`timescale 1ns/10ps
// Data-line switching and detection state for the charger port
module ucpe_line (
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    input  wire logic [2:0]      i_mode,
    input  wire logic            i_sleep,
    input  wire logic            i_cdp_off,
    input  ucpe_pkg::ucpe_cmp_s  i_cmp,
    output ucpe_pkg::ucpe_line_s o_line,
    output logic                 o_shorted
);
    import ucpe_pkg::*;

    typedef enum {L_DETECT, L_SHORTED} ucpe_det_e;
    typedef struct packed {
        ucpe_det_e  st;
        ucpe_line_s line;
    } ucpe_lst_s;

    ucpe_lst_s q, d;
    logic      both_high, both_low;

    assign both_high = i_cmp.port_pos_line_high && i_cmp.port_neg_line_high;
    assign both_low  = !i_cmp.port_pos_line_high && !i_cmp.port_neg_line_high;
    assign o_line    = q.line;
    assign o_shorted = (q.st == L_SHORTED);

    // Switch settings follow the next state, so outputs stay registered
    always_comb begin
        d      = q;
        d.line = '0;
        if (i_sleep || !ucpe_is_auto(i_mode)) begin
            d.st = L_DETECT; // RULE9
        end else begin
            case (q.st)
                L_DETECT:  if (both_high) d.st = L_SHORTED; // RULE2
                L_SHORTED: if (both_low) d.st = L_DETECT; // RULE3
                default:   d.st = L_DETECT;
            endcase
        end
        if (!i_sleep) begin
            case (i_mode)
                autodetect_2a_mode, autodetect_1a_mode: begin
                    d.line.div_en   = (d.st == L_DETECT); // RULE1
                    d.line.short_en = (d.st == L_SHORTED); // RULE2
                end
                passthru_mode:     d.line.xcvr_connect = 1'b1; // RULE11
                forced_short_mode: d.line.short_en = 1'b1;
                passthru_cdp_emul_mode: begin
                    d.line.xcvr_connect = i_cmp.cdp_detected; // RULE12
                    d.line.cdp_adv      = !i_cdp_off; // RULE5 RULE6
                end
                default:           d.line.div_en = 1'b1; // RULE10
            endcase
            // Removal pulls the shared node below both thresholds
            d.line.pulldown_en = d.line.short_en; // RULE4
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** verilog/ucpe_ctrl.sv ***
`timescale 1ns/10ps
// Top of the charge-port emulator control: register bank and line control
//
// Summary of operation
// (RULE1) Auto-detect modes attach dividers to both lines and sense their levels.
// (RULE2) A compliant charger seen on both lines shorts the two lines together.
// (RULE3) On removal the short opens and dividers return for detection.
// (RULE4) While shorted, a pulldown on the shared node exposes removal.
// (RULE5) CDP emulation keeps traffic connected while advertising CDP; the code connects only while CDP is detected.
// (RULE6) The CDP-off bit at 1 suppresses CDP signalling; 0 allows it.
// (RULE7) Software keeps every factory bit at its reset value.
// (RULE8) Software keeps reserved bits at reset values; they do nothing.
// (RULE9) Sleep bit turns off all but the serial port; clearing resumes.
// (RULE10) Three-bit mode field picks auto, pass, forced short or CDP mode.
// (RULE11) Plain pass-through keeps transceiver connected, no dividers or sources.
// (RULE12) CDP mode connects transceiver lines according to CDP detection.
module ucpe_ctrl #(
    parameter logic [6:0] DEV_ADDR      = 7'h2a,
    parameter logic [7:0] CHIP_IDENTITY = 8'h5a
) (
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    input  wire logic            i_scl,
    input  wire logic            i_sda_in,
    output logic                 o_sda_out,
    output logic                 o_sda_oe,
    input  ucpe_pkg::ucpe_cmp_s  i_cmp,
    output ucpe_pkg::ucpe_line_s o_line,
    output logic                 o_shorted
);
    import ucpe_pkg::*;

    // CHIP_IDENTITY default is arbitrary

    typedef struct packed {
        logic [7:0] trim;
        logic [7:0] pwr;
        logic [7:0] mode;
        logic [7:0] rsvd;
        logic [7:0] sw;
        logic [7:0] evt;
        logic [7:0] live;
        logic [7:0] mask;
    } ucpe_regs_s;

    ucpe_regs_s q, d;

    ucpe_bus_s  bus;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] mode_sel;
    logic       sleep;
    logic       cdp_off;
    logic       in_cdp;
    logic [7:0] live_now;
    logic [7:0] live_rise;
    logic       evt_clear;

    // Register read decode, feeding the read data of the slave
    function automatic logic [7:0] ucpe_read(
        input logic [7:0] a,
        input ucpe_regs_s r
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            UCPE_OFS_ID:   v = CHIP_IDENTITY;
            UCPE_OFS_TRIM: v = r.trim;
            UCPE_OFS_PWR:  v = r.pwr;
            UCPE_OFS_MODE: v = r.mode;
            UCPE_OFS_RSVD: v = r.rsvd;
            UCPE_OFS_SW:   v = r.sw;
            UCPE_OFS_EVT:  v = r.evt;
            UCPE_OFS_LIVE: v = r.live;
            UCPE_OFS_MASK: v = r.mask;
            default:       v = 8'h00;
        endcase
        return v;
    endfunction

    // Serial management port stays alive in sleep
    ucpe_i2c #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_scl    (i_scl),
        .i_sda_in (i_sda_in),
        .o_sda_out(o_sda_out),
        .o_sda_oe (o_sda_oe),
        .i_rdata  (rdata),
        .o_rd     (rd),
        .o_bus    (bus)
    );

    assign rdata = ucpe_read(bus.addr, q);

    // Control fields steering the line logic
    assign mode_sel = q.mode[UCPE_MODE_MSB:0]; // RULE10
    assign sleep    = q.pwr[UCPE_SLEEP_BIT]; // RULE9
    assign cdp_off  = q.pwr[UCPE_CDPOFF_BIT]; // RULE6
    assign in_cdp   = (mode_sel == passthru_cdp_emul_mode) && !sleep;

    ucpe_line u_line (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_mode   (mode_sel),
        .i_sleep  (sleep),
        .i_cdp_off(cdp_off),
        .i_cmp    (i_cmp),
        .o_line   (o_line),
        .o_shorted(o_shorted)
    );

    // Live state of the CDP path
    always_comb begin
        live_now                 = 8'h00;
        live_now[UCPE_LIVE_DEV]  = in_cdp && i_cmp.cdp_detected;
        live_now[UCPE_LIVE_BYP]  = in_cdp && cdp_off;
        live_now[UCPE_LIVE_CONN] = in_cdp && o_line.xcvr_connect;
    end

    assign live_rise = live_now & ~q.live;
    // Read of the event byte clears it in the cycle it is captured
    assign evt_clear = rd && (bus.addr == UCPE_OFS_EVT);

    // Register writes; read-only offsets and unmapped ones are ignored
    always_comb begin
        d      = q;
        d.live = live_now;
        // Set beats clear so an edge during the read is not lost
        if (evt_clear) begin
            d.evt = live_rise;
        end else begin
            d.evt = q.evt | live_rise;
        end
        if (bus.wr) begin
            case (bus.addr)
                UCPE_OFS_TRIM: d.trim = bus.wdata;
                UCPE_OFS_PWR:  d.pwr  = bus.wdata;
                UCPE_OFS_MODE: d.mode = bus.wdata;
                UCPE_OFS_RSVD: d.rsvd = bus.wdata;
                UCPE_OFS_SW:   d.sw   = bus.wdata;
                UCPE_OFS_MASK: d.mask = bus.wdata;
                default:       d.mask = q.mask;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q.trim <= UCPE_RST_TRIM;
            q.pwr  <= UCPE_RST_PWR;
            q.mode <= UCPE_RST_MODE;
            q.rsvd <= UCPE_RST_RSVD;
            q.sw   <= UCPE_RST_SW;
            q.evt  <= UCPE_RST_EVT;
            q.live <= UCPE_RST_LIVE;
            q.mask <= UCPE_RST_MASK;
        end else begin
            q <= d;
        end
    end

    // Checks; all in the one clock domain
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    logic auto_on;
    assign auto_on = ucpe_is_auto(mode_sel) && !sleep;

    a_div_in_detect: assert property ( // RULE1
        auto_on && !o_shorted
        && !(i_cmp.port_pos_line_high && i_cmp.port_neg_line_high)
        |=> o_line.div_en && !o_line.short_en && !o_shorted
    ) else $error("dividers not attached while detecting");

    a_short_on_match: assert property ( // RULE2
        auto_on && !o_shorted
        && i_cmp.port_pos_line_high && i_cmp.port_neg_line_high
        |=> o_line.short_en && !o_line.div_en && o_shorted
    ) else $error("lines not shorted after charger seen");

    a_open_on_remove: assert property ( // RULE3
        auto_on && o_shorted
        && !i_cmp.port_pos_line_high && !i_cmp.port_neg_line_high
        |=> o_line.div_en && !o_line.short_en && !o_shorted
    ) else $error("short not opened after removal");

    a_pulldown_held: assert property ( // RULE4
        o_line.short_en |-> o_line.pulldown_en
    ) else $error("pulldown missing while shorted");

    a_cdp_traffic: assert property ( // RULE5
        in_cdp && !cdp_off && i_cmp.cdp_detected
        |=> o_line.cdp_adv && o_line.xcvr_connect && !o_line.div_en
    ) else $error("traffic or advertisement lost in emulation");

    a_cdp_disable: assert property ( // RULE6
        cdp_off |=> !o_line.cdp_adv
    ) else $error("advertisement present while disabled");

    a_cdp_enable: assert property ( // RULE6
        (in_cdp && !cdp_off) [*2] |=> o_line.cdp_adv
    ) else $error("advertisement absent while enabled");

    a_sleep_quiet: assert property ( // RULE9
        sleep |=> o_line == '0 && !o_shorted
    ) else $error("line circuitry active in sleep");

    a_sleep_port: assert property ( // RULE9
        sleep && bus.wr && bus.addr == UCPE_OFS_MODE
        |=> q.mode == $past(bus.wdata)
    ) else $error("register port broken in sleep");

    a_mode_write: assert property ( // RULE10
        bus.wr && bus.addr == UCPE_OFS_MODE
        |=> mode_sel == $past(bus.wdata[UCPE_MODE_MSB:0])
    ) else $error("mode field not updated by write");

    a_pass_through: assert property ( // RULE11
        mode_sel == passthru_mode && !sleep
        |=> o_line.xcvr_connect && !o_line.div_en
            && !o_line.short_en && !o_line.cdp_adv
    ) else $error("pass-through not a plain connection");

    a_cdp_follow: assert property ( // RULE12
        in_cdp |=> o_line.xcvr_connect == $past(i_cmp.cdp_detected)
    ) else $error("connection does not follow detection");

    a_flag_sticky: assert property (
        live_rise[UCPE_LIVE_DEV] |=> q.evt[UCPE_LIVE_DEV]
    ) else $error("event edge lost");

    a_forced_short: assert property ( // RULE10
        mode_sel == forced_short_mode && !sleep
        |=> o_line.short_en && o_line.pulldown_en && !o_line.div_en
    ) else $error("forced short mode not shorting");

    a_fixed_div: assert property ( // RULE10
        mode_sel > autodetect_1a_mode && !sleep
        |=> o_line.div_en && !o_line.short_en && !o_line.xcvr_connect
    ) else $error("forced divider mode wrong");

    a_short_alone: assert property ( // RULE2
        o_line.short_en
        |-> !o_line.xcvr_connect && !o_line.div_en
    ) else $error("short applied with other paths");

    a_pulldown_only: assert property ( // RULE4
        o_line.pulldown_en
        |-> o_line.short_en
    ) else $error("pulldown without short");

    a_shorted_out: assert property ( // RULE2
        o_shorted
        |-> o_line.short_en && !o_line.div_en
    ) else $error("shorted state without short");

    a_adv_in_cdp: assert property ( // RULE5
        o_line.cdp_adv
        |-> $past(in_cdp)
    ) else $error("advertisement outside emulation");

    a_xcvr_modes: assert property ( // RULE11
        o_line.xcvr_connect
        |-> $past(mode_sel) == passthru_mode || $past(in_cdp)
    ) else $error("transceiver connected in charger mode");

    a_wake_resume: assert property ( // RULE9
        $fell(sleep) && ucpe_is_auto(mode_sel)
        |=> o_line.div_en || o_line.short_en
    ) else $error("line logic not resumed on wake");

    a_pwr_write: assert property ( // RULE9
        bus.wr && bus.addr == UCPE_OFS_PWR
        |=> q.pwr == $past(bus.wdata)
    ) else $error("power register not updated by write");

    a_mode_held: assert property ( // RULE10
        !(bus.wr && bus.addr == UCPE_OFS_MODE)
        |=> $stable(q.mode)
    ) else $error("mode field changed without write");

    a_live_bypass: assert property ( // RULE6
        in_cdp && cdp_off
        |=> q.live[UCPE_LIVE_BYP]
    ) else $error("bypass state not shown");

    a_evt_clear: assert property (
        evt_clear && live_rise == 8'h00
        |=> q.evt == 8'h00
    ) else $error("event byte not cleared by read");

    // Main scenarios
    c_short_cycle: cover property (
        !o_shorted ##1 o_shorted ##[1:50] !o_shorted
    );
    c_cdp_adv: cover property (in_cdp && o_line.cdp_adv);
    c_mode_write: cover property (bus.wr && bus.addr == UCPE_OFS_MODE);
    c_evt_read: cover property (evt_clear && q.evt != 8'h00);
endmodule

// *** bench/ucpe_periph_model.sv ***
`timescale 1ns/10ps
// Behavioural attached peripheral: comparator levels and CDP detection outcome
module ucpe_periph_model (
    input  wire logic            i_clk,
    input  ucpe_pkg::ucpe_line_s i_line,
    input  wire logic            i_attach,
    input  wire logic            i_cdp_cap,
    output ucpe_pkg::ucpe_cmp_s  o_cmp
);
    import ucpe_pkg::*;
    logic flip_q = 1'b0;

    // Undriven node wanders, so a held level never passes for a real one
    always_ff @(posedge i_clk) begin
        flip_q <= ~flip_q;
    end

    // Compliant charger lifts both lines; divider or pulldown drags them low once gone
    always_comb begin
        if (i_attach) begin
            o_cmp.port_pos_line_high = 1'b1;
            o_cmp.port_neg_line_high = 1'b1;
        end else if (i_line.div_en || i_line.pulldown_en) begin
            o_cmp.port_pos_line_high = 1'b0;
            o_cmp.port_neg_line_high = 1'b0;
        end else begin
            o_cmp.port_pos_line_high = flip_q;
            o_cmp.port_neg_line_high = ~flip_q;
        end
        // Detection only succeeds while the port advertises CDP
        o_cmp.cdp_detected = i_attach && i_cdp_cap && i_line.cdp_adv;
    end
endmodule

// *** bench/tb_usb_charge_port_emulator_ctrl.sv ***
`timescale 1ns/10ps
// Self-checking bench for the charge-port emulator control block
module tb_usb_charge_port_emulator_ctrl;
    import ucpe_pkg::*;
    localparam logic [6:0] ADDR    = 7'h2a;
    localparam logic [7:0] CHIP_ID = 8'h3c; // Arbitrary identity value
    logic       i_clk    = 1'b0;
    logic       i_resetn = 1'b0;
    logic       i_scl    = 1'b1;
    logic       sda_m    = 1'b1;
    logic       attach   = 1'b0;
    logic       cdp_cap  = 1'b0;
    wire logic  sda;
    logic       sda_out;
    logic       sda_oe;
    logic       shorted;
    ucpe_cmp_s  cmp;
    ucpe_line_s line;
    int         err_count    = 0;
    int         total_checks = 0;

    // Open-drain data line with pull-up
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

    always #5 i_clk = ~i_clk;

    ucpe_ctrl #(.DEV_ADDR(ADDR), .CHIP_IDENTITY(CHIP_ID)) i_dut (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_scl    (i_scl),
        .i_sda_in (sda),
        .o_sda_out(sda_out),
        .o_sda_oe (sda_oe),
        .i_cmp    (cmp),
        .o_line   (line),
        .o_shorted(shorted)
    );

    ucpe_periph_model i_periph (
        .i_clk    (i_clk),
        .i_line   (line),
        .i_attach (attach),
        .i_cdp_cap(cdp_cap),
        .o_cmp    (cmp)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Five clocks per serial phase, above the one the slave needs
    task automatic step();
        repeat (5) @(posedge i_clk);
    endtask

    task automatic do_reset();
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic clock_bit(input logic v, output logic got);
        sda_m <= v;
        step();
        i_scl <= 1'b1;
        step();
        got = sda;
        i_scl <= 1'b0;
        step();
    endtask

    // Also serves as repeated start, since the clock is low between bytes
    task automatic start();
        sda_m <= 1'b1;
        step();
        i_scl <= 1'b1;
        step();
        sda_m <= 1'b0;
        step();
        i_scl <= 1'b0;
        step();
    endtask

    task automatic stop();
        sda_m <= 1'b0;
        step();
        i_scl <= 1'b1;
        step();
        sda_m <= 1'b1;
        step();
    endtask

    task automatic wbyte(input logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], g);
        end
        clock_bit(1'b1, g);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        start();
        wbyte({ADDR, 1'b0});
        wbyte(a);
        wbyte(d);
        stop();
    endtask

    // Single-byte read, master nack ends it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       g;
        start();
        wbyte({ADDR, 1'b0});
        wbyte(a);
        start();
        wbyte({ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(1'b1, g);
        stop();
        check(d, exp);
    endtask

    // Line outputs follow inputs within one clock; three leaves margin
    task automatic line_is(input logic [7:0] exp);
        repeat (3) @(posedge i_clk);
        check({3'h0, line}, exp);
    endtask

    task automatic t_reset();
        logic [7:0] tab [9];
        tab = '{CHIP_ID, 8'h87, 8'h50, 8'he9, 8'h00, 8'h7b, 8'h00, 8'h00, 8'h00};
        line_is(8'h02);
        for (int i = 0; i < 9; i++) begin
            rd_chk(8'(i), tab[i]);
        end
        rd_chk(8'h09, 8'h00);
        reg_wr(8'h00, 8'hff);
        rd_chk(8'h00, CHIP_ID);
        reg_wr(8'h04, 8'h00);
        rd_chk(8'h04, 8'h00);
    endtask

    // Both automatic modes: attach, short, remove, back to detection
    task automatic t_auto();
        logic [7:0] md [2];
        md = '{8'he8, 8'hec};
        for (int i = 0; i < 2; i++) begin
            attach <= 1'b0;
            reg_wr(8'h03, md[i]);
            line_is(8'h10);
            check({7'h0, shorted}, 8'h00);
            attach <= 1'b1;
            line_is(8'h0c);
            check({7'h0, shorted}, 8'h01);
            attach <= 1'b0;
            line_is(8'h10);
            check({7'h0, shorted}, 8'h00);
        end
    endtask

    task automatic t_modes();
        logic [7:0] md [5];
        logic [7:0] ex [5];
        md = '{8'hea, 8'he9, 8'hed, 8'hee, 8'hef};
        ex = '{8'h0c, 8'h02, 8'h10, 8'h10, 8'h10};
        attach <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            reg_wr(8'h03, md[i]);
            line_is(ex[i]);
        end
        attach <= 1'b0;
    endtask

    // Factory bits of the power register are written back at reset value
    task automatic t_cdp();
        attach <= 1'b1;
        cdp_cap <= 1'b1;
        reg_wr(8'h03, 8'heb);
        line_is(8'h03);
        rd_chk(8'h06, 8'ha0);
        rd_chk(8'h06, 8'h00);
        reg_wr(8'h02, 8'h52);
        line_is(8'h00);
        rd_chk(8'h07, 8'h40);
        reg_wr(8'h02, 8'h50);
        line_is(8'h03);
        cdp_cap <= 1'b0;
        line_is(8'h01);
    endtask

    task automatic t_sleep();
        reg_wr(8'h02, 8'hd0);
        line_is(8'h00);
        rd_chk(8'h03, 8'heb);
        reg_wr(8'h03, 8'he8);
        line_is(8'h00);
        reg_wr(8'h02, 8'h50);
        line_is(8'h0c);
        attach <= 1'b0;
        line_is(8'h10);
    endtask

    // Second reset in mid-run returns to pass-through
    task automatic t_rereset();
        reg_wr(8'h03, 8'hea);
        do_reset();
        line_is(8'h02);
        rd_chk(8'h03, 8'he9);
    endtask

    initial begin
        do_reset();
        t_reset();
        t_auto();
        t_modes();
        t_cdp();
        t_sleep();
        t_rereset();
        final_report();
    end

    // Tests need about 17k clocks; this bound only trips on a hang
    initial begin
        repeat (50000) @(posedge i_clk);
        err_count++;
        final_report();
    end
endmodule
